// ===== rtl/otpprg_defs.svh
`ifndef OTPPRG_DEFS_SVH
`define OTPPRG_DEFS_SVH
`define OTPPRG_ADDR_FIRST      17'h00000
`define OTPPRG_ADDR_LAST       17'h0EFFF
`define OTPPRG_PAGE_BYTES      3'h4
`define OTPPRG_MAX_TRIES       4'hA
`define OTPPRG_PULSE_NS        100000
`define OTPPRG_CLK_NS          10
`define OTPPRG_PULSE_CYC       (`OTPPRG_PULSE_NS / `OTPPRG_CLK_NS)
`define OTPPRG_SETUP_CYC       8'h04
`define OTPPRG_SAMPLE_CYC      8'h08
`endif

// ===== rtl/otpprg_pkg.sv
package otpprg_pkg;
   typedef enum logic [1:0] {
      OTPPRG_CMD_READ  = 2'h0,
      OTPPRG_CMD_BYTE  = 2'h1,
      OTPPRG_CMD_PAGE  = 2'h2
   } otpprg_cmd_t;

   typedef struct packed {
      logic       reset_n;
      logic       vpp_high;
      logic       ce_n;
      logic       oe_n;
      logic       program_strobe_n;
      logic [16:0] addr;
      logic [7:0] dout;
      logic       doe;
   } otpprg_pins_t;

   typedef struct packed {
      logic       done;
      logic       fail;
      logic [7:0] rdata;
      logic       busy;
   } otpprg_rsp_t;
endpackage

// ===== rtl/otpprg_sync.sv
`timescale 1ns/100ps
`default_nettype none
module otpprg_sync #(
   parameter int WIDTH = 8
) (
   // Clock and reset
   input  wire logic             clk_sys_i,
   input  wire logic             rstn_i,
   // Data
   input  wire logic [WIDTH-1:0] d_i,
   output logic      [WIDTH-1:0] q_o
);
   typedef struct packed {
      logic [WIDTH-1:0] s1;
      logic [WIDTH-1:0] s2;
      logic [WIDTH-1:0] s3;
      logic [WIDTH-1:0] q;
   } otpprg_sync_t;

   otpprg_sync_t r;
   otpprg_sync_t next_r;

   // Only the second and third stages feed the agreement check
   always_comb begin
      next_r    = r;
      next_r.s1 = d_i;
      next_r.s2 = r.s1;
      next_r.s3 = r.s2;
      if (r.s2 == r.s3) begin
         next_r.q = r.s3;
      end
   end

   always_ff @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end

   assign q_o = r.q;
endmodule // otpprg_sync
`default_nettype wire

// ===== rtl/otpprg_host.sv
// Function
// - Enter mode: supply raised for writes only, reset held low
// - Select one shared device by output enable
// - Page latch: CE high, strobe high, OE low
// - Page pulse 0.1 ms, CE/OE high, then verify
// - Byte pulse 0.1 ms, CE low OE high
// - Retry pulse and verify, ten tries max
// - Write range 0000H to EFFFH, last explicit
// - Latch four incrementing addresses, pulse, verify
// - Read: reset low, address, read mode, sample
`timescale 1ns/100ps
`default_nettype none
`include "otpprg_defs.svh"
module otpprg_host
   import otpprg_pkg::*;
#(
   parameter int PULSE_CYC  = `OTPPRG_PULSE_CYC,
   parameter int PAGE_BYTES = `OTPPRG_PAGE_BYTES
) (
   // Clock and reset
   input  wire logic          clk_sys_i,
   input  wire logic          rstn_i,
   // Command port
   input  wire logic          req_i,
   input  wire otpprg_cmd_t   cmd_i,
   input  wire logic [16:0]   addr_i,
   input  wire logic [31:0]   wdata_i,
   output otpprg_rsp_t        rsp_o,
   // Device pins
   input  wire logic [7:0]    data_pin_i,
   output otpprg_pins_t       pins_o
);
   typedef enum logic [3:0] {
      ST_IDLE   = 4'h0,
      ST_ENTER  = 4'h1,
      ST_LATCH  = 4'h3,
      ST_LGAP   = 4'h2,
      ST_PSETUP = 4'h6,
      ST_PULSE  = 4'h7,
      ST_PHOLD  = 4'h5,
      ST_VFY    = 4'h4,
      ST_VSAMP  = 4'hC,
      ST_DONE   = 4'hD
   } otpprg_st_t;

   typedef struct packed {
      otpprg_st_t   st;
      otpprg_cmd_t  cmd;
      otpprg_pins_t pins;
      otpprg_rsp_t  rsp;
      logic [16:0]  base;
      logic [31:0]  wdata;
      logic [2:0]   idx;
      logic [3:0]   tries;
      logic [31:0]  cnt;
      logic         bad;
   } otpprg_state_t;

   otpprg_state_t r;
   otpprg_state_t next_r;
   logic [7:0]    din;
   logic [7:0]    exp_byte;
   logic [17:0]   addr_end;

   otpprg_sync #(.WIDTH(8)) u_sync (
      .clk_sys_i (clk_sys_i),
      .rstn_i    (rstn_i),
      .d_i       (data_pin_i),
      .q_o       (din)
   );

   assign exp_byte = r.wdata[{r.idx[1:0], 3'h0} +: 8];

   // Pages that would run past the last address are refused as a whole
   assign addr_end = {1'b0, addr_i} +
                     ((cmd_i == OTPPRG_CMD_PAGE) ? 18'(PAGE_BYTES - 1) : 18'h0);

   always_comb begin
      next_r          = r;
      next_r.rsp.done = 1'b0;
      case (r.st)
         ST_IDLE: begin
            next_r.pins.doe              = 1'b0;
            next_r.pins.ce_n             = 1'b1;
            next_r.pins.oe_n             = 1'b1;
            next_r.pins.program_strobe_n = 1'b1;
            if (req_i && ((cmd_i == OTPPRG_CMD_READ) ||
                          (addr_end <= {1'b0, `OTPPRG_ADDR_LAST}))) begin
               next_r.cmd            = cmd_i;
               next_r.base           = addr_i;
               next_r.wdata          = wdata_i;
               next_r.idx            = 3'h0;
               next_r.tries          = 4'h0;
               next_r.cnt            = 32'h0;
               next_r.bad            = 1'b0;
               next_r.rsp.busy       = 1'b1;
               next_r.pins.reset_n   = 1'b0;
               next_r.pins.vpp_high  = (cmd_i != OTPPRG_CMD_READ);
               next_r.st             = ST_ENTER;
            end else if (req_i) begin
               next_r.rsp.done = 1'b1;
               next_r.rsp.fail = 1'b1;
            end
         end
         ST_ENTER: begin
            next_r.cnt = r.cnt + 32'h1;
            if (r.cnt[7:0] == `OTPPRG_SETUP_CYC) begin
               next_r.cnt       = 32'h0;
               next_r.pins.addr = r.base;
               case (r.cmd)
                  OTPPRG_CMD_PAGE: begin
                     next_r.st = ST_LATCH;
                  end
                  OTPPRG_CMD_BYTE: begin
                     next_r.st = ST_PSETUP;
                  end
                  default: begin
                     next_r.st = ST_VFY;
                  end
               endcase
            end
         end
         ST_LATCH: begin
            // Address and byte presented with CE high, strobe high, OE low
            next_r.pins.addr             = r.base + {15'h0, r.idx[1:0]};
            next_r.pins.dout             = exp_byte;
            next_r.pins.doe              = 1'b1;
            next_r.pins.ce_n             = 1'b1;
            next_r.pins.program_strobe_n = 1'b1;
            next_r.cnt                   = r.cnt + 32'h1;
            if (r.cnt[7:0] == `OTPPRG_SETUP_CYC) begin
               next_r.pins.oe_n = 1'b0;
            end
            if (r.cnt[7:0] == `OTPPRG_SAMPLE_CYC) begin
               next_r.pins.oe_n = 1'b1;
               next_r.cnt       = 32'h0;
               next_r.st        = ST_LGAP;
            end
         end
         ST_LGAP: begin
            if (r.idx == 3'(PAGE_BYTES - 1)) begin
               next_r.idx = 3'h0;
               next_r.st  = ST_PSETUP;
            end else begin
               next_r.idx = r.idx + 3'h1;
               next_r.st  = ST_LATCH;
            end
         end
         ST_PSETUP: begin
            // Byte write keeps CE low; page write keeps CE high
            next_r.pins.oe_n = 1'b1;
            next_r.pins.ce_n = (r.cmd == OTPPRG_CMD_BYTE) ? 1'b0 : 1'b1;
            next_r.pins.dout = exp_byte;
            next_r.pins.doe  = (r.cmd == OTPPRG_CMD_BYTE);
            next_r.cnt       = r.cnt + 32'h1;
            if (r.cnt[7:0] == `OTPPRG_SETUP_CYC) begin
               next_r.cnt                   = 32'h0;
               next_r.pins.program_strobe_n = 1'b0;
               next_r.tries                 = r.tries + 4'h1;
               next_r.st                    = ST_PULSE;
            end
         end
         ST_PULSE: begin
            // Address and data are not touched while the strobe is low
            next_r.cnt = r.cnt + 32'h1;
            if (r.cnt == 32'(PULSE_CYC - 1)) begin
               next_r.cnt                   = 32'h0;
               next_r.pins.program_strobe_n = 1'b1;
               next_r.st                    = ST_PHOLD;
            end
         end
         ST_PHOLD: begin
            next_r.cnt = r.cnt + 32'h1;
            if (r.cnt[7:0] == `OTPPRG_SETUP_CYC) begin
               next_r.cnt      = 32'h0;
               next_r.pins.doe = 1'b0;
               next_r.idx      = 3'h0;
               next_r.bad      = 1'b0;
               next_r.st       = ST_VFY;
            end
         end
         ST_VFY: begin
            // Data lines released before device drives them
            next_r.pins.doe              = 1'b0;
            next_r.pins.addr             = r.base + {15'h0, r.idx[1:0]};
            next_r.pins.ce_n             = 1'b0;
            next_r.pins.program_strobe_n = 1'b1;
            next_r.pins.oe_n             = 1'b0;
            next_r.cnt                   = r.cnt + 32'h1;
            if (r.cnt[7:0] == `OTPPRG_SAMPLE_CYC) begin
               next_r.cnt = 32'h0;
               next_r.st  = ST_VSAMP;
            end
         end
         ST_VSAMP: begin
            next_r.pins.oe_n = 1'b1;
            next_r.rsp.rdata = din;
            if ((r.cmd != OTPPRG_CMD_READ) && (din != exp_byte)) begin
               next_r.bad = 1'b1;
            end
            if ((r.cmd == OTPPRG_CMD_PAGE) && (r.idx != 3'(PAGE_BYTES - 1))) begin
               next_r.idx = r.idx + 3'h1;
               next_r.st  = ST_VFY;
            end else if ((r.cmd == OTPPRG_CMD_READ) ||
                         !(r.bad || (din != exp_byte))) begin
               next_r.rsp.fail = 1'b0;
               next_r.st       = ST_DONE;
            end else if (r.tries == `OTPPRG_MAX_TRIES) begin
               next_r.rsp.fail = 1'b1;
               next_r.st       = ST_DONE;
            end else begin
               next_r.pins.ce_n = 1'b1;
               next_r.idx       = 3'h0;
               // Page retries reuse the bytes already latched in the part
               next_r.st        = ST_PSETUP;
            end
         end
         ST_DONE: begin
            next_r.pins.ce_n     = 1'b1;
            next_r.pins.oe_n     = 1'b1;
            next_r.pins.vpp_high = 1'b0;
            next_r.rsp.busy      = 1'b0;
            next_r.rsp.done      = 1'b1;
            next_r.st            = ST_IDLE;
         end
         default: begin
            next_r.st = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
         r                       <= '0;
         r.pins.reset_n          <= 1'b0;
         r.pins.ce_n             <= 1'b1;
         r.pins.oe_n             <= 1'b1;
         r.pins.program_strobe_n <= 1'b1;
      end else begin
         r <= next_r;
      end
   end

   assign pins_o = r.pins;
   assign rsp_o  = r.rsp;
endmodule // otpprg_host
`default_nettype wire

// ===== dv/otpprg_host_monitor.sv
`timescale 1ns/100ps
`default_nettype none
module otpprg_host_monitor
   import otpprg_pkg::*;
#(
   parameter int PULSE_CYC = 20
) (
   // Watched ports
   input wire logic         clk_sys_i,
   input wire logic         rstn_i,
   input wire logic         req_i,
   input wire otpprg_cmd_t  cmd_i,
   input wire logic [16:0]  addr_i,
   input wire otpprg_rsp_t  rsp_o,
   input wire otpprg_pins_t pins_o
);
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (!rstn_i);
   wire logic lo = !pins_o.program_strobe_n;
   wire logic go = req_i && !rsp_o.busy;
   int   lo_n;
   int   pulses;
   logic lo_q;
   // Pulses are counted per command so a runaway retry loop shows
   always_ff @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
         lo_n <= 0;
         pulses <= 0;
         lo_q <= 1'b0;
      end else begin
         lo_n <= lo ? lo_n + 1 : 0;
         pulses <= rsp_o.done ? 0 : pulses + int'(lo && !lo_q);
         lo_q <= lo;
      end
   end
   chk_reset_low: assert property (!pins_o.reset_n) else $error("reset pin raised");
   chk_vpp_pulse: assert property (lo |-> pins_o.vpp_high) else $error("pulse, no supply");
   chk_pulse_oe: assert property (lo |-> pins_o.oe_n) else $error("pulse with oe low");
   chk_pulse_width: assert property ($rose(pins_o.program_strobe_n) |-> lo_n == PULSE_CYC)
      else $error("pulse width wrong");
   chk_addr_hold: assert property (lo && $past(lo) |-> $stable(pins_o.addr)
      && $stable(pins_o.dout)) else $error("lines moved in pulse");
   chk_no_clash: assert property (pins_o.doe |-> pins_o.oe_n || pins_o.ce_n)
      else $error("host drives into read");
   chk_try_limit: assert property (pulses <= 10) else $error("too many pulses");
   chk_refuse_high: assert property (go && cmd_i != OTPPRG_CMD_READ && addr_i > 17'h0EFFF
      |-> ##[1:2] rsp_o.done && rsp_o.fail) else $error("high write not refused");
   chk_refuse_page: assert property (go && cmd_i == OTPPRG_CMD_PAGE && addr_i > 17'h0EFFC
      |-> ##1 rsp_o.done && rsp_o.fail) else $error("page overrun not refused");
   chk_read_win: assert property (go && cmd_i == OTPPRG_CMD_READ |-> ##[2:40]
      !pins_o.ce_n && !pins_o.oe_n && pins_o.program_strobe_n) else $error("no read window");
   chk_done_once: assert property (rsp_o.done |=> !rsp_o.done) else $error("done too long");
   cover property ($rose(lo) && pins_o.ce_n);
   cover property ($rose(lo) && !pins_o.ce_n);
   cover property (rsp_o.done && rsp_o.fail);
endmodule // otpprg_host_monitor
bind otpprg_host otpprg_host_monitor #(.PULSE_CYC(PULSE_CYC)) u_otpprg_host_monitor (
   .clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .req_i(req_i), .cmd_i(cmd_i),
   .addr_i(addr_i), .rsp_o(rsp_o), .pins_o(pins_o));
`default_nettype wire

// ===== dv/otpprg_dev_model.sv
`timescale 1ns/100ps
`default_nettype none
module otpprg_dev_model
   import otpprg_pkg::*;
(
   // Pins and fault control
   input  wire otpprg_pins_t pins_i,
   input  wire logic [3:0]   skip_i,
   output logic [7:0]        bus_o
);
   logic [7:0] mem [int];
   logic [7:0] lat [int];
   logic [7:0] last = 8'h00;
   int         miss = 0;
   wire logic  mode = !pins_i.reset_n;
   wire logic  drv = mode && !pins_i.ce_n && !pins_i.oe_n && pins_i.program_strobe_n;
   function automatic logic [7:0] rdm(int a);
      return mem.exists(a) ? mem[a] : 8'hFF;
   endfunction
   // Released lines show the inverse of the last value, never a stale copy
   always @* begin
      if (pins_i.doe) bus_o = drv ? 8'hXX : pins_i.dout;
      else bus_o = drv ? rdm(pins_i.addr) : ~last;
   end
   always @(bus_o) if (pins_i.doe || drv) last = bus_o;
   always @(pins_i) begin
      if (mode && pins_i.ce_n && pins_i.program_strobe_n && !pins_i.oe_n && pins_i.doe) begin
         lat[pins_i.addr] = pins_i.dout;
      end
   end
   // Fresh miss budget for every write command, even with an unchanged skip count
   always @(skip_i or posedge pins_i.vpp_high) miss = 0;
   // Ignored pulses model a weak cell that needs retries
   always @(negedge pins_i.program_strobe_n) begin
      if (!mode || !pins_i.vpp_high || !pins_i.oe_n) miss = miss;
      else if (miss < skip_i) miss++;
      else if (!pins_i.ce_n) mem[pins_i.addr] = rdm(pins_i.addr) & pins_i.dout;
      else begin
         foreach (lat[a]) mem[a] = rdm(a) & lat[a];
         lat.delete();
      end
   end
endmodule // otpprg_dev_model
`default_nettype wire

// ===== dv/otpprg_host_tb.sv
`timescale 1ns/100ps
`default_nettype none
module otpprg_host_tb;
   import otpprg_pkg::*;
   logic         clk_sys_i = 1'b0;
   logic         rstn_i = 1'b0;
   logic         req_i = 1'b0;
   otpprg_cmd_t  cmd_i = OTPPRG_CMD_READ;
   logic [16:0]  addr_i = 17'h00000;
   logic [31:0]  wdata_i = 32'h00000000;
   logic [3:0]   skip = 4'h0;
   logic [7:0]   bus;
   otpprg_rsp_t  rsp_o;
   otpprg_pins_t pins_o;
   logic [7:0]   ref_mem [int];
   int           errors = 0;
   int           checks_done = 0;
   otpprg_host #(.PULSE_CYC(20)) u_otpprg_host (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i),
      .req_i(req_i), .cmd_i(cmd_i), .addr_i(addr_i), .wdata_i(wdata_i), .rsp_o(rsp_o),
      .data_pin_i(bus), .pins_o(pins_o));
   otpprg_dev_model u_otpprg_dev_model (.pins_i(pins_o), .skip_i(skip), .bus_o(bus));
   initial begin
      forever #5 clk_sys_i = ~clk_sys_i;
   end
   task automatic check(logic [31:0] seen, logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         errors++;
         $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
      end
   endtask
   task automatic test_done();
      $display("errors %0d checks %0d", errors, checks_done);
      if (errors == 0 && checks_done > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   function automatic logic [7:0] rm(int a);
      return ref_mem.exists(a) ? ref_mem[a] : 8'hFF;
   endfunction
   // Cells only program ones to zeros, so a rewrite may never verify
   task automatic run(otpprg_cmd_t c, logic [16:0] a, logic [31:0] d, logic [3:0] s);
      logic bad;
      int   k;
      int   nb;
      int   last;
      nb = (c == OTPPRG_CMD_PAGE) ? 4 : 1;
      last = a + nb - 1;
      bad = (c != OTPPRG_CMD_READ) && (last > 17'h0EFFF || s >= 4'hA);
      if (c != OTPPRG_CMD_READ && last <= 17'h0EFFF) begin
         for (k = 0; k < nb; k++) begin
            if ((rm(a + k) & d[8 * k +: 8]) != d[8 * k +: 8]) bad = 1'b1;
            if (s < 4'hA) ref_mem[a + k] = rm(a + k) & d[8 * k +: 8];
         end
      end
      @(posedge clk_sys_i);
      #1;
      skip = s;
      cmd_i = c;
      addr_i = a;
      wdata_i = d;
      req_i = 1'b1;
      @(posedge clk_sys_i);
      #1;
      req_i = 1'b0;
      check(rsp_o.busy, c == OTPPRG_CMD_READ || last <= 17'h0EFFF);
      for (k = 0; k < 3000 && rsp_o.done !== 1'b1; k++) begin
         @(posedge clk_sys_i);
         #1;
      end
      if (k == 3000) begin
         errors++;
         test_done();
      end
      check(rsp_o.fail, bad);
      if (last <= 17'h0EFFF) check(rsp_o.rdata, rm(last));
   endtask
   initial begin
      int          i;
      logic [16:0] a;
      void'($urandom(40166));
      repeat (2) @(posedge clk_sys_i);
      #1;
      rstn_i = 1'b1;
      check({pins_o.reset_n, pins_o.ce_n, pins_o.oe_n, pins_o.program_strobe_n,
         pins_o.doe}, 5'h0E);
      run(OTPPRG_CMD_READ, 17'h00010, 32'h0, 4'h0);
      run(OTPPRG_CMD_BYTE, 17'h0EFFF, 32'h5A, 4'h0);
      run(OTPPRG_CMD_BYTE, 17'h0F000, 32'h5A, 4'h0);
      run(OTPPRG_CMD_PAGE, 17'h10000, 32'h0, 4'h0);
      run(OTPPRG_CMD_PAGE, 17'h0EFFE, 32'h0, 4'h0);
      run(OTPPRG_CMD_BYTE, 17'h00100, 32'h3C, 4'h9);
      run(OTPPRG_CMD_BYTE, 17'h00101, 32'h3C, 4'hA);
      run(OTPPRG_CMD_BYTE, 17'h00100, 32'hFF, 4'h0);
      run(OTPPRG_CMD_PAGE, 17'h00200, 32'h12345678, 4'h3);
      run(OTPPRG_CMD_READ, 17'h00201, 32'h0, 4'h0);
      for (i = 0; i < 14; i++) begin
         a = 17'($urandom_range(17'h0EFFC));
         run(otpprg_cmd_t'($urandom_range(2)), a, $urandom, 4'($urandom_range(3)));
         run(OTPPRG_CMD_READ, a + 17'($urandom_range(3)), 32'h0, 4'h0);
      end
      test_done();
   end
endmodule // otpprg_host_tb
`default_nettype wire
